// ===== verilog/vic_top.sv
// interrupt controller register block with ahb-lite slave port
// assumes one clock; sources are level and held until serviced
`include "vic_defines.svh"
module vic_top
	import vic_pkg::*;
#(
	parameter vic_normal_t NORMAL_ACTIVE_HIGH       = '1,
	parameter vic_fast_t   FAST_ACTIVE_HIGH         = '1,
	parameter bit          FAST_PATH_PRESENT_PARAM  = 1'b1,
	// identity values are arbitrary
	parameter logic [31:0] VERSION_ID               = 32'h0000_0101,
	parameter logic [31:0] TYPE_ID                  = 32'h0000_0202
)
(
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic      [1:0]  hresp_o,
	input  wire logic [39:0] normal_src_i,
	input  wire logic [1:0]  fast_src_i,
	output logic             normal_irq_o,
	output logic             fast_irq_o
);
	// ==========================================================
	// bus address phase capture
	// ==========================================================
	logic      sel_q;
	logic      wr_q;
	vic_addr_t addr_q;
	logic      take_req;

	// transfer size not checked; word accesses assumed // RULE20
	assign take_req = hsel_i & htrans_i[1] & hready_i;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sel_q  <= 1'b0;
			wr_q   <= 1'b0;
			addr_q <= '0;
		end
		else if (hready_i)
		begin
			sel_q  <= take_req;
			wr_q   <= take_req & hwrite_i;
			addr_q <= haddr_i[`VIC_ADDR_W-1:0];
		end
	end

	// no wait states, no errors
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 2'b00;

	// ==========================================================
	// address decoding
	// ==========================================================
	function automatic logic prio_hit(input vic_addr_t a);
		prio_hit = (a >= `VIC_OFF_PRIO_BASE) && (a[1:0] == 2'b00)
			&& (a < (`VIC_OFF_PRIO_BASE + 10'(`VIC_NUM_NORMAL * 4)));
	endfunction

	function automatic logic [5:0] prio_index(input vic_addr_t a);
		vic_addr_t d;
		d = a - `VIC_OFF_PRIO_BASE;
		prio_index = d[7:2];
	endfunction

	function automatic vic_level_t prio_reset(input int n);
		prio_reset = 4'(n % `VIC_PRIO_GROUP); // RULE18
	endfunction

	logic       wr_phase;
	logic       prio_wr_hit;
	logic [5:0] prio_wr_idx;

	assign wr_phase    = sel_q & wr_q;
	assign prio_wr_hit = wr_phase & prio_hit(addr_q);
	assign prio_wr_idx = prio_index(addr_q);

	// ==========================================================
	// writable registers
	// ==========================================================
	logic [31:0] en_lo_q;
	logic [7:0]  en_hi_q;
	logic [31:0] mask_lo_q;
	logic [7:0]  mask_hi_q;
	logic [31:0] force_lo_q;
	logic [7:0]  force_hi_q;
	vic_fast_t   fast_en_q;
	vic_fast_t   fast_mask_q;
	vic_fast_t   fast_force_q;
	vic_level_t  threshold_q;
	vic_prio_t   prio_q;

	// force bits reset to the inactive level of each input // RULE5
	localparam vic_normal_t FORCE_RST      = ~NORMAL_ACTIVE_HIGH;
	localparam vic_fast_t   FAST_FORCE_RST = ~FAST_ACTIVE_HIGH;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_lo_q      <= `VIC_RST_ZERO32;   // RULE1
			en_hi_q      <= 8'h00;             // RULE2
			mask_lo_q    <= `VIC_RST_ZERO32;   // RULE3
			mask_hi_q    <= 8'h00;
			force_lo_q   <= FORCE_RST[31:0];   // RULE5
			force_hi_q   <= FORCE_RST[39:32];
			fast_en_q    <= 2'h0;              // RULE10
			fast_mask_q  <= 2'h0;
			fast_force_q <= FAST_FORCE_RST;
			threshold_q  <= `VIC_RST_THRESHOLD; // RULE16
		end
		else if (wr_phase)
		begin
			// reserved bits dropped, read-only targets ignored // RULE24
			case (addr_q)
				`VIC_OFF_EN_LO:      en_lo_q      <= hwdata_i;       // RULE1
				`VIC_OFF_EN_HI:      en_hi_q      <= hwdata_i[7:0];  // RULE2
				`VIC_OFF_MASK_LO:    mask_lo_q    <= hwdata_i;       // RULE3
				`VIC_OFF_MASK_HI:    mask_hi_q    <= hwdata_i[7:0];
				`VIC_OFF_FORCE_LO:   force_lo_q   <= hwdata_i;       // RULE4
				`VIC_OFF_FORCE_HI:   force_hi_q   <= hwdata_i[7:0];
				`VIC_OFF_FAST_EN:    fast_en_q    <= hwdata_i[1:0];  // RULE10
				`VIC_OFF_FAST_MASK:  fast_mask_q  <= FAST_PATH_PRESENT_PARAM
					? hwdata_i[1:0] : 2'h0;                          // RULE11
				`VIC_OFF_FAST_FORCE: fast_force_q <= hwdata_i[1:0];  // RULE12
				`VIC_OFF_THRESHOLD:  threshold_q  <= hwdata_i[3:0];  // RULE16
				default:             ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < `VIC_NUM_NORMAL; g++)
		begin : g_prio
			always_ff @(posedge clock_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					prio_q[g] <= prio_reset(g); // RULE18
				else if (prio_wr_hit && (prio_wr_idx == 6'(g)))
					prio_q[g] <= hwdata_i[3:0]; // RULE17
			end
		end
	endgenerate

	// ==========================================================
	// interrupt path
	// ==========================================================
	vic_path_if path_if ();

	assign path_if.src         = normal_src_i;
	assign path_if.enable      = {en_hi_q, en_lo_q};
	assign path_if.mask        = {mask_hi_q, mask_lo_q};
	assign path_if.force_bits  = {force_hi_q, force_lo_q};
	assign path_if.prio        = prio_q;
	assign path_if.threshold   = threshold_q;
	assign path_if.fast_src    = fast_src_i;
	assign path_if.fast_enable = fast_en_q;
	assign path_if.fast_mask   = fast_mask_q;
	assign path_if.fast_force  = fast_force_q;

	vic_irq_path #(
		.NORMAL_ACTIVE_HIGH (NORMAL_ACTIVE_HIGH),
		.FAST_ACTIVE_HIGH   (FAST_ACTIVE_HIGH)
	) u_path (
		.p (path_if.path)
	);

	// no flops between sources and outputs // RULE21
	assign normal_irq_o = |path_if.filtered;     // RULE23 RULE25
	assign fast_irq_o   = |path_if.fast_filtered; // RULE23 RULE25

	// ==========================================================
	// read data, live from the combinational stages
	// ==========================================================
	logic [31:0] rd_reg;
	logic [31:0] rd_prio;

	assign rd_prio = {28'h0000000, prio_q[prio_wr_idx]};

	always_comb
	begin
		rd_reg = 32'h0000_0000;
		case (addr_q)
			`VIC_OFF_EN_LO:         rd_reg = en_lo_q;
			`VIC_OFF_EN_HI:         rd_reg = {24'h000000, en_hi_q};
			`VIC_OFF_MASK_LO:       rd_reg = mask_lo_q;
			`VIC_OFF_MASK_HI:       rd_reg = {24'h000000, mask_hi_q};
			`VIC_OFF_FORCE_LO:      rd_reg = force_lo_q;
			`VIC_OFF_FORCE_HI:      rd_reg = {24'h000000, force_hi_q};
			`VIC_OFF_RAW_LO:        rd_reg = path_if.raw[31:0];                     // RULE6
			`VIC_OFF_RAW_HI:        rd_reg = {24'h000000, path_if.raw[39:32]};      // RULE6
			`VIC_OFF_ENABLED_LO:    rd_reg = path_if.enabled[31:0];                 // RULE7
			`VIC_OFF_ENABLED_HI:    rd_reg = {24'h000000, path_if.enabled[39:32]};  // RULE7
			`VIC_OFF_UNMASKED_LO:   rd_reg = path_if.unmasked[31:0];                // RULE8
			`VIC_OFF_UNMASKED_HI:   rd_reg = {24'h000000, path_if.unmasked[39:32]}; // RULE8
			`VIC_OFF_FILTERED_LO:   rd_reg = path_if.filtered[31:0];                // RULE9
			`VIC_OFF_FILTERED_HI:   rd_reg = {24'h000000, path_if.filtered[39:32]}; // RULE9
			`VIC_OFF_FAST_EN:       rd_reg = {30'h00000000, fast_en_q};
			`VIC_OFF_FAST_MASK:     rd_reg = {30'h00000000, fast_mask_q};           // RULE11
			`VIC_OFF_FAST_FORCE:    rd_reg = {30'h00000000, fast_force_q};
			`VIC_OFF_FAST_RAW:      rd_reg = {30'h00000000, path_if.fast_raw};      // RULE13
			`VIC_OFF_FAST_ENABLED:  rd_reg = {30'h00000000, path_if.fast_enabled};  // RULE14
			`VIC_OFF_FAST_FILTERED: rd_reg = {30'h00000000, path_if.fast_filtered}; // RULE15
			`VIC_OFF_THRESHOLD:     rd_reg = {28'h0000000, threshold_q};
			`VIC_OFF_VERSION:       rd_reg = VERSION_ID; // RULE19
			`VIC_OFF_TYPE:          rd_reg = TYPE_ID;    // RULE19
			default:                rd_reg = prio_hit(addr_q) ? rd_prio : 32'h0000_0000; // RULE24
		endcase
	end

	// read data valid in the data phase of a selected read
	assign hrdata_o = (sel_q && !wr_q) ? rd_reg : 32'h0000_0000;

endmodule // vic_top

// ===== verilog/vic_defines.svh
// constants of the vectored interrupt controller register block
// assumes inclusion by bare name from the package and the top module
//
// Behaviour
// RULE1 - low 32 normal sources have enable bits
// RULE2 - upper 8 enables in bits 7:0
// RULE3 - mask bit one blocks; resets unmasked
// RULE4 - normal force bits follow input polarity
// RULE5 - all force bits reset inactive
// RULE6 - raw status reads live source levels
// RULE7 - status shows active-or-forced and enabled
// RULE8 - mask status adds the unmasked condition
// RULE9 - final status after priority filtering
// RULE10 - two fast enables, reset zero
// RULE11 - fast mask exists only with fast path
// RULE12 - fast force bits follow input polarity
// RULE13 - fast raw status reads live inputs
// RULE14 - fast status is forced-or-active and enabled
// RULE15 - fast final status after masking only
// RULE16 - 4-bit threshold, pass priority at or above
// RULE17 - per-source 4-bit priority at word stride
// RULE18 - priority resets n, n-16, n-32
// RULE19 - read-only version and type identity words
// RULE20 - master uses full 32-bit word accesses
// RULE21 - interrupt path purely combinational, reads live
// RULE22 - priority zero is the lowest level
// RULE23 - one normal and one fast output
// RULE24 - reserved and unmapped read zero, ignore writes
// RULE25 - outputs assert on any final bit
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_NUM_NORMAL        40
`define VIC_NUM_FAST          2
`define VIC_ADDR_W            10

`define VIC_OFF_EN_LO         10'h000
`define VIC_OFF_EN_HI         10'h004
`define VIC_OFF_MASK_LO       10'h008
`define VIC_OFF_MASK_HI       10'h00c
`define VIC_OFF_FORCE_LO      10'h010
`define VIC_OFF_FORCE_HI      10'h014
`define VIC_OFF_RAW_LO        10'h018
`define VIC_OFF_RAW_HI        10'h01c
`define VIC_OFF_ENABLED_LO    10'h020
`define VIC_OFF_ENABLED_HI    10'h024
`define VIC_OFF_UNMASKED_LO   10'h028
`define VIC_OFF_UNMASKED_HI   10'h02c
`define VIC_OFF_FILTERED_LO   10'h030
`define VIC_OFF_FILTERED_HI   10'h034
`define VIC_OFF_FAST_EN       10'h0c0
`define VIC_OFF_FAST_MASK     10'h0c4
`define VIC_OFF_FAST_FORCE    10'h0c8
`define VIC_OFF_FAST_RAW      10'h0cc
`define VIC_OFF_FAST_ENABLED  10'h0d0
`define VIC_OFF_FAST_FILTERED 10'h0d4
`define VIC_OFF_THRESHOLD     10'h0d8
`define VIC_OFF_PRIO_BASE     10'h0e8
`define VIC_OFF_VERSION       10'h3f8
`define VIC_OFF_TYPE          10'h3fc

`define VIC_RST_ZERO32        32'h0000_0000
`define VIC_RST_THRESHOLD     4'h0
`define VIC_PRIO_GROUP        16

`endif

// ===== verilog/vic_pkg.sv
// types shared by the interrupt controller modules
// assumes vic_defines.svh is on the include path
package vic_pkg;
`include "vic_defines.svh"

	typedef logic [`VIC_NUM_NORMAL-1:0]        vic_normal_t;
	typedef logic [`VIC_NUM_FAST-1:0]          vic_fast_t;
	typedef logic [3:0]                        vic_level_t;
	typedef logic [`VIC_NUM_NORMAL-1:0][3:0]   vic_prio_t;
	typedef logic [`VIC_ADDR_W-1:0]            vic_addr_t;

endpackage

// ===== verilog/vic_path_if.sv
// settings and stage results between register file and interrupt path
// assumes vic_pkg compiled first
interface vic_path_if;
	import vic_pkg::*;

	vic_normal_t src;
	vic_normal_t enable;
	vic_normal_t mask;
	vic_normal_t force_bits;
	vic_prio_t   prio;
	vic_level_t  threshold;
	vic_fast_t   fast_src;
	vic_fast_t   fast_enable;
	vic_fast_t   fast_mask;
	vic_fast_t   fast_force;
	vic_normal_t raw;
	vic_normal_t enabled;
	vic_normal_t unmasked;
	vic_normal_t filtered;
	vic_fast_t   fast_raw;
	vic_fast_t   fast_enabled;
	vic_fast_t   fast_filtered;

	modport regs (
		output src, enable, mask, force_bits, prio, threshold,
		output fast_src, fast_enable, fast_mask, fast_force,
		input  raw, enabled, unmasked, filtered,
		input  fast_raw, fast_enabled, fast_filtered
	);
	modport path (
		input  src, enable, mask, force_bits, prio, threshold,
		input  fast_src, fast_enable, fast_mask, fast_force,
		output raw, enabled, unmasked, filtered,
		output fast_raw, fast_enabled, fast_filtered
	);
endinterface

// ===== verilog/vic_irq_path.sv
// combinational forcing, enabling, masking and priority filter stages
// assumes settings come from the register file through vic_path_if
`include "vic_defines.svh"
module vic_irq_path
	import vic_pkg::*;
#(
	parameter vic_normal_t NORMAL_ACTIVE_HIGH = '1,
	parameter vic_fast_t   FAST_ACTIVE_HIGH   = '1
)
(
	vic_path_if.path p
);
	// ==========================================================
	// normal sources
	// ==========================================================
	vic_normal_t forced;
	vic_normal_t prio_ok;

	// polarity-adjusted view of inputs and force bits
	assign p.raw      = ~(p.src ^ NORMAL_ACTIVE_HIGH);        // RULE6 RULE21
	assign forced     = ~(p.force_bits ^ NORMAL_ACTIVE_HIGH); // RULE4
	assign p.enabled  = (p.raw | forced) & p.enable;          // RULE7 RULE1 RULE2
	assign p.unmasked = p.enabled & ~p.mask;                  // RULE8 RULE3

	genvar n;
	generate
		for (n = 0; n < `VIC_NUM_NORMAL; n++)
		begin : g_filter
			// unsigned compare, level zero lowest
			assign prio_ok[n] = (p.prio[n] >= p.threshold); // RULE16 RULE22
		end
	endgenerate

	assign p.filtered = p.unmasked & prio_ok; // RULE9

	// ==========================================================
	// fast sources
	// ==========================================================
	vic_fast_t fast_forced;

	assign p.fast_raw      = ~(p.fast_src ^ FAST_ACTIVE_HIGH);          // RULE13
	assign fast_forced     = ~(p.fast_force ^ FAST_ACTIVE_HIGH);        // RULE12
	assign p.fast_enabled  = (p.fast_raw | fast_forced) & p.fast_enable; // RULE14 RULE10
	assign p.fast_filtered = p.fast_enabled & ~p.fast_mask;            // RULE15 RULE11

endmodule // vic_irq_path

// ===== testbench/vic_top_checker.sv
// port assertions for vic_top
// assumes default active-high source polarity and word accesses
module vic_top_checker
	import vic_pkg::*;
#(
	parameter logic [31:0] VERSION_ID = 32'h0000_0101,
	parameter logic [31:0] TYPE_ID    = 32'h0000_0202
)
(
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic [1:0]  hresp_o,
	input wire logic [39:0] normal_src_i,
	input wire logic [1:0]  fast_src_i,
	input wire logic        normal_irq_o,
	input wire logic        fast_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================
	// data phase tracking
	logic       rd_q;
	logic       wr_q;
	logic [9:0] a_q;
	wire logic  req      = hsel_i & htrans_i[1] & hready_i;
	wire logic  hole     = (a_q > 10'h034 && a_q < 10'h0c0) || (a_q > 10'h0d8 && a_q < 10'h0e8)
		|| (a_q > 10'h184 && a_q < 10'h3f8);
	wire logic  hi_reg   = a_q[2] && a_q <= 10'h034;
	wire logic  fast_reg = a_q >= 10'h0c0 && a_q <= 10'h0d4;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{rd_q, wr_q, a_q} <= '0;
		else
			{rd_q, wr_q, a_q} <= {req & ~hwrite_i, req & hwrite_i, haddr_i[9:0]};
	end

	// ======================================
	// assertions
	property p_ok;
		@(posedge clock_i) disable iff (!rst_n_i) hreadyout_o && hresp_o == 2'h0;
	endproperty
	a_ok: assert property (p_ok) else $error("bus answer not ready or not okay");
	property p_idle;
		@(posedge clock_i) disable iff (!rst_n_i) !rd_q |-> hrdata_o == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read phase");
	property p_hole;
		@(posedge clock_i) disable iff (!rst_n_i) rd_q && hole |-> hrdata_o == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped offset not zero");
	property p_hi;
		@(posedge clock_i) disable iff (!rst_n_i) rd_q && hi_reg |-> hrdata_o[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("high register reserved bits set");
	property p_fast;
		@(posedge clock_i) disable iff (!rst_n_i) rd_q && fast_reg |-> hrdata_o[31:2] == 30'h0;
	endproperty
	a_fast: assert property (p_fast) else $error("fast register reserved bits set");
	property p_raw;
		@(posedge clock_i) disable iff (!rst_n_i)
			rd_q && a_q == 10'h018 |-> hrdata_o == normal_src_i[31:0];
	endproperty
	a_raw: assert property (p_raw) else $error("raw low not live sources");
	property p_fraw;
		@(posedge clock_i) disable iff (!rst_n_i)
			rd_q && a_q == 10'h0cc |-> hrdata_o == {30'h0, fast_src_i};
	endproperty
	a_fraw: assert property (p_fraw) else $error("fast raw not live sources");
	property p_id;
		@(posedge clock_i) disable iff (!rst_n_i)
			rd_q && a_q[9:3] == 7'h7f |-> hrdata_o == (a_q[2] ? TYPE_ID : VERSION_ID);
	endproperty
	a_id: assert property (p_id) else $error("identity word wrong");
	property p_rst;
		@(posedge clock_i) disable iff (!rst_n_i) $rose(rst_n_i) |-> !normal_irq_o && !fast_irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("request out of reset");
	property p_comb;
		@(posedge clock_i) disable iff (!rst_n_i)
			$changed(normal_irq_o) |-> $changed(normal_src_i) || $past(wr_q);
	endproperty
	a_comb: assert property (p_comb) else $error("request moved without cause");
endmodule // vic_top_checker

// ===== testbench/vic_core_model.sv
// processor core side: counts request entries
// assumes the two request outputs of vic_top
module vic_core_model
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       normal_irq_i,
	input  wire logic       fast_irq_i,
	output logic      [7:0] normal_taken_o,
	output logic      [7:0] fast_taken_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen_q;
	logic fseen_q;

	// one entry per new request on each line
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{seen_q, fseen_q, normal_taken_o, fast_taken_o} <= '0;
		else
		begin
			seen_q <= normal_irq_i;
			fseen_q <= fast_irq_i;
			normal_taken_o <= normal_taken_o + {7'h0, normal_irq_i & ~seen_q};
			fast_taken_o <= fast_taken_o + {7'h0, fast_irq_i & ~fseen_q};
		end
	end
endmodule // vic_core_model

// ===== testbench/tb_top.sv
// self-checking bench of vic_top with a core model
// assumes default active-high sources
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] VER = 32'h0000_0a51; // arbitrary value
	localparam logic [31:0] TYP = 32'h0000_0b62; // arbitrary value
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hsel_i = 1'b0;
	logic        hwrite_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [39:0] normal_src_i = 40'h0;
	logic [1:0]  fast_src_i = 2'h0;
	logic [31:0] hrdata_o;
	logic [1:0]  hresp_o;
	logic        hreadyout_o;
	logic        normal_irq_o;
	logic        fast_irq_o;
	logic [7:0]  n_taken;
	logic [7:0]  f_taken;
	logic        nf_fast_irq;
	int          n_errors = 0;
	int          samples_checked = 0;

	vic_top #(.VERSION_ID(VER), .TYPE_ID(TYP)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(1'b1), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .normal_src_i(normal_src_i),
		.fast_src_i(fast_src_i), .normal_irq_o(normal_irq_o), .fast_irq_o(fast_irq_o));
	vic_core_model core (.clock_i(clock_i), .rst_n_i(rst_n_i), .normal_irq_i(normal_irq_o),
		.fast_irq_i(fast_irq_o), .normal_taken_o(n_taken), .fast_taken_o(f_taken));
	// second instance built without the fast mask register
	vic_top #(.FAST_PATH_PRESENT_PARAM(1'b0)) dut_nf (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(1'b1), .hrdata_o(), .hreadyout_o(),
		.hresp_o(), .normal_src_i(normal_src_i), .fast_src_i(fast_src_i), .normal_irq_o(),
		.fast_irq_o(nf_fast_irq));

	// ======================================
	// bus and pin tasks
	task automatic req(input logic s, input logic w, input logic [9:0] a);
		hsel_i <= s;
		htrans_i <= {s, 1'b0};
		hwrite_i <= w;
		haddr_i <= {22'h0, a};
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req(1'b1, 1'b1, a);
		@(posedge clock_i);
		req(1'b0, 1'b0, a);
		hwdata_i <= d;
		@(posedge clock_i);
	endtask
	task automatic rchk(input logic [9:0] a, input logic [31:0] e);
		@(posedge clock_i);
		req(1'b1, 1'b0, a);
		@(posedge clock_i);
		req(1'b0, 1'b0, a);
		@(negedge clock_i);
		`CHK(hrdata_o, e)
	endtask
	task automatic ichk(input logic n, input logic f);
		@(negedge clock_i);
		`CHK({normal_irq_o, fast_irq_o}, {n, f})
	endtask
	task automatic drv(input logic [39:0] n, input logic [1:0] f);
		@(posedge clock_i);
		normal_src_i <= n;
		fast_src_i <= f;
	endtask

	// ======================================
	// scenarios
	task automatic t_reset;
		for (int a = 0; a < 'he8; a += 4)
			rchk(a[9:0], 32'h0);
		for (int n = 0; n < 40; n++)
			rchk(10'(32'he8 + 4 * n), 32'(n % 16));
		rchk(10'h3f8, VER);
		rchk(10'h3fc, TYP);
		rchk(10'h188, 32'h0);
	endtask
	task automatic t_regs;
		logic [9:0] off [9] = '{10'h000, 10'h004, 10'h008, 10'h00c, 10'h0c0, 10'h0c4,
			10'h0d8, 10'h0e8, 10'h184};
		logic [31:0] msk [9] = '{32'hffff_ffff, 32'h0000_00ff, 32'hffff_ffff, 32'h0000_00ff,
			32'h3, 32'h3, 32'hf, 32'hf, 32'hf};
		for (int i = 0; i < 9; i++)
		begin
			wr(off[i], 32'hffff_ffff);
			rchk(off[i], msk[i]);
			wr(off[i], 32'h0);
		end
		wr(10'h184, 32'h7);
		wr(10'h018, 32'hffff_ffff);
		rchk(10'h018, 32'h0);
		wr(10'h3f8, 32'h0);
		rchk(10'h3f8, VER);
	endtask
	task automatic t_path;
		logic [7:0] n0;
		drv(40'h08_0000_0008, 2'h0);
		rchk(10'h018, 32'h8);
		rchk(10'h01c, 32'h8);
		rchk(10'h020, 32'h0);
		n0 = n_taken;
		wr(10'h000, 32'h8);
		wr(10'h004, 32'h8);
		rchk(10'h024, 32'h8);
		rchk(10'h02c, 32'h8);
		rchk(10'h030, 32'h8);
		ichk(1'b1, 1'b0);
		`CHK(n_taken, n0 + 8'h1)
		wr(10'h00c, 32'h8);
		rchk(10'h034, 32'h0);
		rchk(10'h028, 32'h8);
		wr(10'h008, 32'h8);
		ichk(1'b0, 1'b0);
		wr(10'h008, 32'h0);
		wr(10'h00c, 32'h0);
		wr(10'h0d8, 32'h4);
		ichk(1'b0, 1'b0);
		wr(10'h0d8, 32'h3);
		rchk(10'h030, 32'h8);
		wr(10'h0d8, 32'hf);
		wr(10'h0f4, 32'hf);
		rchk(10'h030, 32'h8);
		rchk(10'h034, 32'h0);
		wr(10'h0f4, 32'h3);
		wr(10'h0d8, 32'h0);
		drv(40'h0, 2'h0);
		wr(10'h010, 32'h8);
		wr(10'h014, 32'h1);
		rchk(10'h018, 32'h0);
		rchk(10'h020, 32'h8);
		rchk(10'h024, 32'h0);
		ichk(1'b1, 1'b0);
		wr(10'h010, 32'h0);
		wr(10'h014, 32'h0);
	endtask
	task automatic t_fast;
		logic [7:0] f0;
		f0 = f_taken;
		drv(40'h0, 2'h1);
		rchk(10'h0cc, 32'h1);
		rchk(10'h0d0, 32'h0);
		wr(10'h0c0, 32'h3);
		rchk(10'h0d4, 32'h1);
		ichk(1'b0, 1'b1);
		wr(10'h0c4, 32'h1);
		ichk(1'b0, 1'b0);
		`CHK(nf_fast_irq, 1'b1)
		wr(10'h0c8, 32'h2);
		wr(10'h0d8, 32'hf);
		rchk(10'h0d0, 32'h3);
		rchk(10'h0d4, 32'h2);
		`CHK(f_taken, f0 + 8'h2)
		wr(10'h0d8, 32'h0);
	endtask
	task automatic t_rerst;
		wr(10'h000, 32'hffff_ffff);
		drv(40'h1, 2'h1);
		ichk(1'b1, 1'b1);
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		ichk(1'b0, 1'b0);
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		rchk(10'h000, 32'h0);
		rchk(10'h0c8, 32'h0);
		rchk(10'h0f4, 32'h3);
	endtask

	task automatic wrap_up;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		forever #25 clock_i = ~clock_i;
	end
	initial
	begin
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_regs;
		t_path;
		t_fast;
		t_rerst;
		wrap_up;
	end
	initial
	begin
		repeat (20000) @(posedge clock_i);
		n_errors++;
		wrap_up;
	end
endmodule // tb_top

bind vic_top vic_top_checker #(.VERSION_ID(VERSION_ID), .TYPE_ID(TYPE_ID)) u_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.normal_src_i(normal_src_i), .fast_src_i(fast_src_i), .normal_irq_o(normal_irq_o),
	.fast_irq_o(fast_irq_o));
